/* pmc_pkg.sv */
package pmc_pkg;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] PMC_CAP_HDR_OFS = 8'h40;
    localparam logic [7:0] PMC_CTL_STS_OFS = 8'h44;
    localparam logic [7:0] PMC_MSI_HDR_OFS = 8'h4c;

    // ****************************************
    // Fixed codes
    // ****************************************
    localparam logic [7:0] PMC_PM_CAP_ID = 8'h01;
    localparam logic [7:0] PMC_MSI_CAP_ID = 8'h05;
    localparam logic [7:0] PMC_NEXT_UP_RST = 8'h5c;
    localparam logic [7:0] PMC_NEXT_DN_RST = 8'h4c;
    localparam logic [7:0] PMC_MSI_NEXT_RST = 8'h64;
    localparam logic [2:0] PMC_PM_REV = 3'h3;

    // ****************************************
    // Header field positions
    // ****************************************
    localparam int PMC_ID_LSB = 0;
    localparam int PMC_NEXT_LSB = 8;
    localparam int PMC_REV_LSB = 16;
    localparam int PMC_DSI_BIT = 21;
    localparam int PMC_AUX_LSB = 22;
    localparam int PMC_D1_BIT = 25;
    localparam int PMC_D2_BIT = 26;
    localparam int PMC_PMES_LSB = 27;

    // ****************************************
    // Control/status field positions
    // ****************************************
    localparam int PMC_PS_LSB = 0;
    localparam int PMC_NSR_BIT = 3;
    localparam int PMC_PMEEN_BIT = 8;
    localparam int PMC_DSEL_LSB = 9;
    localparam int PMC_DATA_LSB = 24;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic PMC_DSI_RST = 1'b0;
    localparam logic [2:0] PMC_AUX_RST = 3'h7;
    localparam logic PMC_D1_RST = 1'b1;
    localparam logic PMC_D2_RST = 1'b1;
    localparam logic [4:0] PMC_PMES_RST = 5'h1f;
    localparam logic PMC_NSR_RST = 1'b1;
    localparam logic PMC_PMEEN_RST = 1'b0;
    localparam logic [3:0] PMC_DSEL_RST = 4'h0;
    localparam logic [7:0] PMC_DATA_RST = 8'h00;

    typedef enum logic [1:0] {
        PMC_D0 = 2'b00,
        PMC_D1 = 2'b01,
        PMC_D2 = 2'b10,
        PMC_D3HOT = 2'b11
    } pmc_state_e;

endpackage : pmc_pkg

/* pmc_regs.sv */
// What this block does
// - Capability identifier byte of the power header always reads the power capability code.
// - Next pointer resets to one value upstream, another on downstream ports.
// - Revision field reads the fixed code for power interface revision 1.2.
// - Legacy clock bit and both bridge extension bits are hardwired zero.
// - Device specific initialization flag reads zero by default.
// - Auxiliary current field resets to all ones, maximum draw in D3.
// - D1 and D2 support flags each read one by default.
// - Event support field reads all ones by default.
// - Loadable read-only defaults can be replaced through the side load port.
// - Two-bit power state field reports current state D0, D1, D2, D3hot.
// - Writing D0 after D3hot causes hot reset, downstream reset stays deasserted.
// - No-soft-reset flag resets one; when zero, D3hot to D0 resets internally.
// - Event enable bit resets zero; when set, event messages are permitted.
// - Data select resets zero; data byte resets zero, loadable; scale reads zero.
// - Event status bit always reads zero.
// - Downstream ports show an interrupt capability header, fixed id, next pointer 64h.
module pmc_regs #(
    parameter bit DOWNSTREAM_PORT = 1'b0
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Configuration access
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [3:0] CFG_BE,
    input wire logic [31:0] CFG_WDATA,
    output logic [31:0] CFG_RDATA,
    output logic CFG_RVALID,
    // Default load from serial management or EEPROM
    input wire logic LOAD_WR,
    input wire logic [7:0] LOAD_ADDR,
    input wire logic [3:0] LOAD_BE,
    input wire logic [31:0] LOAD_DATA,
    // Power state and reset signalling
    output pmc_pkg::pmc_state_e POWER_STATE,
    output logic PME_ENABLE,
    output logic [3:0] DATA_SELECT,
    output logic HOT_RESET,
    output logic INTERNAL_RESET,
    output logic DOWNSTREAM_RESET_OUT_N
);
    import pmc_pkg::*;

    // ****************************************
    // Loadable defaults
    // ****************************************
    logic dsi_reg, dsi_next;
    logic [2:0] aux_reg, aux_next;
    logic d1_reg, d1_next;
    logic d2_reg, d2_next;
    logic [4:0] pmes_reg, pmes_next;
    logic nsr_reg, nsr_next;
    logic [7:0] data_reg, data_next;

    // Load port only touches loadable bits; byte enables select lanes
    always_comb begin
        dsi_next = dsi_reg;
        aux_next = aux_reg;
        d1_next = d1_reg;
        d2_next = d2_reg;
        pmes_next = pmes_reg;
        nsr_next = nsr_reg;
        data_next = data_reg;
        if (LOAD_WR && LOAD_ADDR == PMC_CAP_HDR_OFS) begin
            if (LOAD_BE[2]) begin
                dsi_next = LOAD_DATA[PMC_DSI_BIT];
                aux_next[1:0] = LOAD_DATA[PMC_AUX_LSB+:2];
            end
            if (LOAD_BE[3]) begin
                aux_next[2] = LOAD_DATA[PMC_AUX_LSB+2];
                d1_next = LOAD_DATA[PMC_D1_BIT];
                d2_next = LOAD_DATA[PMC_D2_BIT];
                pmes_next = LOAD_DATA[PMC_PMES_LSB+:5];
            end
        end
        if (LOAD_WR && LOAD_ADDR == PMC_CTL_STS_OFS) begin
            if (LOAD_BE[0]) begin
                nsr_next = LOAD_DATA[PMC_NSR_BIT];
            end
            if (LOAD_BE[3]) begin
                data_next = LOAD_DATA[PMC_DATA_LSB+:8];
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            dsi_reg <= PMC_DSI_RST;
            aux_reg <= PMC_AUX_RST;
            d1_reg <= PMC_D1_RST;
            d2_reg <= PMC_D2_RST;
            pmes_reg <= PMC_PMES_RST;
            nsr_reg <= PMC_NSR_RST;
            data_reg <= PMC_DATA_RST;
        end else begin
            dsi_reg <= dsi_next;
            aux_reg <= aux_next;
            d1_reg <= d1_next;
            d2_reg <= d2_next;
            pmes_reg <= pmes_next;
            nsr_reg <= nsr_next;
            data_reg <= data_next;
        end
    end

    // ****************************************
    // Power state control
    // ****************************************
    pmc_state_e state_reg, state_next;
    logic pmeen_reg, pmeen_next;
    logic [3:0] dsel_reg, dsel_next;
    logic hot_reg, hot_next;
    logic irst_reg, irst_next;
    logic ctl_wr;
    logic state_ok;

    assign ctl_wr = CFG_WR && CFG_ADDR == PMC_CTL_STS_OFS;

    // Unsupported intermediate states are refused, so software sees no change
    always_comb begin
        unique case (pmc_state_e'(CFG_WDATA[PMC_PS_LSB+:2]))
            PMC_D1: state_ok = d1_reg;
            PMC_D2: state_ok = d2_reg;
            default: state_ok = 1'b1;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        pmeen_next = pmeen_reg;
        dsel_next = dsel_reg;
        hot_next = 1'b0;
        irst_next = 1'b0;
        if (ctl_wr && CFG_BE[0] && state_ok) begin
            state_next = pmc_state_e'(CFG_WDATA[PMC_PS_LSB+:2]);
            if (state_reg == PMC_D3HOT && state_next == PMC_D0) begin
                hot_next = 1'b1;
                irst_next = !nsr_reg;
            end
        end
        if (ctl_wr && CFG_BE[1]) begin
            pmeen_next = CFG_WDATA[PMC_PMEEN_BIT];
            dsel_next = CFG_WDATA[PMC_DSEL_LSB+:4];
        end
        // Soft reset returns the writable fields to defaults
        if (irst_next) begin
            pmeen_next = PMC_PMEEN_RST;
            dsel_next = PMC_DSEL_RST;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg <= PMC_D0;
            pmeen_reg <= PMC_PMEEN_RST;
            dsel_reg <= PMC_DSEL_RST;
            hot_reg <= 1'b0;
            irst_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            pmeen_reg <= pmeen_next;
            dsel_reg <= dsel_next;
            hot_reg <= hot_next;
            irst_reg <= irst_next;
        end
    end

    assign POWER_STATE = state_reg;
    assign PME_ENABLE = pmeen_reg;
    assign DATA_SELECT = dsel_reg;
    assign HOT_RESET = hot_reg;
    assign INTERNAL_RESET = irst_reg;
    // Hot reset from a power state change never reaches the downstream pin
    assign DOWNSTREAM_RESET_OUT_N = 1'b1;

    // ****************************************
    // Read path
    // ****************************************
    logic [31:0] hdr_word, ctl_word, msi_word;
    logic [31:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;

    // Unlisted bits stay zero: reserved, legacy clock, bridge bits, status
    always_comb begin
        hdr_word = 32'h0000_0000;
        hdr_word[PMC_ID_LSB+:8] = PMC_PM_CAP_ID;
        hdr_word[PMC_NEXT_LSB+:8] = DOWNSTREAM_PORT ? PMC_NEXT_DN_RST : PMC_NEXT_UP_RST;
        hdr_word[PMC_REV_LSB+:3] = PMC_PM_REV;
        hdr_word[PMC_DSI_BIT] = dsi_reg;
        hdr_word[PMC_AUX_LSB+:3] = aux_reg;
        hdr_word[PMC_D1_BIT] = d1_reg;
        hdr_word[PMC_D2_BIT] = d2_reg;
        hdr_word[PMC_PMES_LSB+:5] = pmes_reg;
        ctl_word = 32'h0000_0000;
        ctl_word[PMC_PS_LSB+:2] = state_reg;
        ctl_word[PMC_NSR_BIT] = nsr_reg;
        ctl_word[PMC_PMEEN_BIT] = pmeen_reg;
        ctl_word[PMC_DSEL_LSB+:4] = dsel_reg;
        ctl_word[PMC_DATA_LSB+:8] = data_reg;
        msi_word = 32'h0000_0000;
        msi_word[PMC_ID_LSB+:8] = PMC_MSI_CAP_ID;
        msi_word[PMC_NEXT_LSB+:8] = PMC_MSI_NEXT_RST;
    end

    always_comb begin
        rvalid_next = CFG_RD;
        rdata_next = 32'h0000_0000;
        if (CFG_RD) begin
            if (CFG_ADDR == PMC_CAP_HDR_OFS) begin
                rdata_next = hdr_word;
            end else if (CFG_ADDR == PMC_CTL_STS_OFS) begin
                rdata_next = ctl_word;
            end else if (CFG_ADDR == PMC_MSI_HDR_OFS && DOWNSTREAM_PORT) begin
                rdata_next = msi_word;
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_reg <= 32'h0000_0000;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign CFG_RDATA = rdata_reg;
    assign CFG_RVALID = rvalid_reg;

endmodule : pmc_regs

/* pmc_regs_asserts.sv */
module pmc_regs_asserts
    import pmc_pkg::*;
#(
    parameter bit DOWNSTREAM_PORT = 1'b0
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [3:0] CFG_BE,
    input wire logic [31:0] CFG_WDATA,
    input wire logic [31:0] CFG_RDATA,
    input wire logic CFG_RVALID,
    input pmc_pkg::pmc_state_e POWER_STATE,
    input wire logic PME_ENABLE,
    input wire logic [3:0] DATA_SELECT,
    input wire logic HOT_RESET,
    input wire logic INTERNAL_RESET,
    input wire logic DOWNSTREAM_RESET_OUT_N
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    // ****************************************
    // Read path
    // ****************************************
    read_ack_a: assert property (CFG_RD |=> CFG_RVALID)
        else $error("read not answered next cycle");
    read_idle_a: assert property (!CFG_RD |=> !CFG_RVALID && CFG_RDATA == 32'h0)
        else $error("read strobe or data without request");
    cap_fixed_a: assert property (CFG_RD && CFG_ADDR == 8'h40 |=>
        CFG_RDATA[7:0] == 8'h01 && CFG_RDATA[20:16] == 5'h03) else $error("header fixed bits");
    next_ptr_a: assert property (CFG_RD && CFG_ADDR == 8'h40 |=>
        CFG_RDATA[15:8] == (DOWNSTREAM_PORT ? 8'h4c : 8'h5c)) else $error("next pointer");
    ctl_zero_a: assert property (CFG_RD && CFG_ADDR == 8'h44 |=>
        CFG_RDATA[23:13] == 11'h0 && CFG_RDATA[7:4] == 4'h0 && !CFG_RDATA[2])
        else $error("control word zero bits");
    msi_hdr_a: assert property (CFG_RD && CFG_ADDR == 8'h4c |=>
        CFG_RDATA == (DOWNSTREAM_PORT ? 32'h6405 : 32'h0)) else $error("interrupt header");
    // ****************************************
    // Power state and resets
    // ****************************************
    state_hold_a: assert property (!CFG_WR |=> $stable(POWER_STATE))
        else $error("power state moved without write");
    hot_rst_a: assert property (CFG_WR && CFG_ADDR == 8'h44 && CFG_BE[0]
        && CFG_WDATA[1:0] == 2'b00 && POWER_STATE == PMC_D3HOT |=> HOT_RESET && POWER_STATE == PMC_D0)
        else $error("no hot reset on wake");
    hot_cause_a: assert property (HOT_RESET |-> $past(POWER_STATE) == PMC_D3HOT)
        else $error("hot reset without prior deep state");
    int_rst_a: assert property (INTERNAL_RESET |-> HOT_RESET && !PME_ENABLE
        && DATA_SELECT == 4'h0) else $error("internal reset effects");
    dn_rst_a: assert property (DOWNSTREAM_RESET_OUT_N)
        else $error("downstream reset asserted");
    hot_c: cover property (HOT_RESET && !INTERNAL_RESET);
    int_c: cover property (INTERNAL_RESET);
    msi_c: cover property (CFG_RD && CFG_ADDR == 8'h4c);
endmodule : pmc_regs_asserts

bind pmc_regs pmc_regs_asserts #(.DOWNSTREAM_PORT(DOWNSTREAM_PORT)) chk_u (.CLK(CLK), .NRST(NRST),
    .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE),
    .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID),
    .POWER_STATE(POWER_STATE), .PME_ENABLE(PME_ENABLE), .DATA_SELECT(DATA_SELECT),
    .HOT_RESET(HOT_RESET), .INTERNAL_RESET(INTERNAL_RESET),
    .DOWNSTREAM_RESET_OUT_N(DOWNSTREAM_RESET_OUT_N));

/* tb_pmc_regs.sv */
module tb_pmc_regs;
    timeunit 1ns;
    timeprecision 100ps;
    import pmc_pkg::*;
    logic clk = 0, nrst = 0, cfg_wr = 0, cfg_rd = 0, load_wr = 0;
    logic [7:0] cfg_addr = 8'h0, load_addr = 8'h0;
    logic [3:0] cfg_be = 4'h0, load_be = 4'h0, data_select;
    logic [31:0] cfg_wdata = 32'h0, load_data = 32'h0, cfg_rdata;
    logic cfg_rvalid, pme_enable, hot_reset, internal_reset, dn_rst_n;
    pmc_state_e power_state;
    int error_cnt = 0, compares = 0;
    always #5 clk = ~clk;
    pmc_regs #(.DOWNSTREAM_PORT(1'b1)) dut_u (.CLK(clk), .NRST(nrst), .CFG_WR(cfg_wr),
        .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr), .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata),
        .CFG_RDATA(cfg_rdata), .CFG_RVALID(cfg_rvalid), .LOAD_WR(load_wr), .LOAD_ADDR(load_addr),
        .LOAD_BE(load_be), .LOAD_DATA(load_data), .POWER_STATE(power_state),
        .PME_ENABLE(pme_enable), .DATA_SELECT(data_select), .HOT_RESET(hot_reset),
        .INTERNAL_RESET(internal_reset), .DOWNSTREAM_RESET_OUT_N(dn_rst_n));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // The wr, ld and rd tasks start and end just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        cfg_wr = 1; cfg_addr = a; cfg_be = be; cfg_wdata = d;
        @(posedge clk); #1;
        cfg_wr = 0;
    endtask : wr
    task automatic ld(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        load_wr = 1; load_addr = a; load_be = be; load_data = d;
        @(posedge clk); #1;
        load_wr = 0;
    endtask : ld
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        cfg_rd = 1; cfg_addr = a;
        @(posedge clk); #1;
        cfg_rd = 0;
        check("rvalid", {31'h0, cfg_rvalid}, 32'h1);
        check("rdata", cfg_rdata, exp);
    endtask : rd
    task automatic conclude;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    initial begin
        #20000;
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 nrst = 1;
        rd(8'h40, 32'hffc34c01);
        rd(8'h44, 32'h00000008);
        rd(8'h4c, 32'h00006405);
        rd(8'h48, 32'h0);
        wr(8'h40, 4'hf, 32'h0);
        wr(8'h4c, 4'hf, 32'h0);
        rd(8'h40, 32'hffc34c01);
        rd(8'h4c, 32'h00006405);
        wr(8'h44, 4'hf, 32'hffffffff);
        rd(8'h44, 32'h00001f0b);
        check("pme", {31'h0, pme_enable}, 32'h1);
        check("dsel", {28'h0, data_select}, 32'hf);
        for (int s = 1; s < 4; s++) begin
            wr(8'h44, 4'h1, s);
            check("state", {30'h0, power_state}, s);
        end
        wr(8'h44, 4'h1, 32'h0);
        check("hot", {hot_reset, internal_reset, pme_enable, power_state}, 5'h14);
        @(posedge clk); #1;
        check("hot end", {31'h0, hot_reset}, 32'h0);
        check("dn rst", {31'h0, dn_rst_n}, 32'h1);
        ld(8'h44, 4'h9, 32'haa000000);
        rd(8'h44, 32'haa001f00);
        wr(8'h44, 4'h1, 32'h3);
        wr(8'h44, 4'h1, 32'h0);
        check("int", {hot_reset, internal_reset, pme_enable, data_select}, 7'h60);
        ld(8'h40, 4'hc, 32'h0);
        rd(8'h40, 32'h00034c01);
        wr(8'h44, 4'h1, 32'h1);
        check("no d1", {30'h0, power_state}, 32'h0);
        ld(8'h40, 4'hf, 32'hffffffff);
        rd(8'h40, 32'hffe34c01);
        conclude();
    end
endmodule : tb_pmc_regs
